//--- fdc_pkg.sv
// Shared constants and types of the dual clock FIFO control block.
// Assumes a single core clock that samples both FIFO port clocks as pins.
`default_nettype none

package fdc_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int unsigned FDC_DATA_W  = 18;
   localparam int unsigned FDC_DEPTH   = 8192;
   localparam int unsigned FDC_ADDR_W  = 13;
   localparam int unsigned FDC_OFS_W   = 13;

   // ----------------------------------------------------------------
   // Default flag offsets chosen at master reset
   // ----------------------------------------------------------------
   localparam logic [12:0] FDC_OFS_PARALLEL_DEF = 13'h007f;
   localparam logic [12:0] FDC_OFS_SERIAL_DEF   = 13'h03ff;

   // ----------------------------------------------------------------
   // Pin sampling: positions in the synchronised pin vector
   // ----------------------------------------------------------------
   localparam int unsigned FDC_SYNC_STAGES = 3;
   localparam int unsigned FDC_PIN_WCLK    = 0;
   localparam int unsigned FDC_PIN_WEN     = 1;
   localparam int unsigned FDC_PIN_RCLK    = 2;
   localparam int unsigned FDC_PIN_REN     = 3;
   localparam int unsigned FDC_PIN_RT      = 4;
   localparam int unsigned FDC_PIN_MRS     = 5;
   localparam int unsigned FDC_PIN_PRS     = 6;
   localparam int unsigned FDC_PIN_MODE    = 7;
   localparam int unsigned FDC_PIN_LD      = 8;
   localparam int unsigned FDC_PIN_SEN     = 9;
   localparam int unsigned FDC_PIN_DATA    = 10;
   localparam int unsigned FDC_PIN_W       = FDC_PIN_DATA + FDC_DATA_W;

   // ----------------------------------------------------------------
   // Read side sequencing
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      FDC_RD_RUN,
      FDC_RD_REPLAY
   } fdc_rd_state_type;

endpackage : fdc_pkg

`default_nettype wire

//--- fdc_mem_if.sv
// Connection between the FIFO controller and its storage array.
// Assumes both ends run on the same core clock.
`default_nettype none

interface fdc_mem_if #(
   parameter int unsigned DW = 18,
   parameter int unsigned AW = 13
);
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;

   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : fdc_mem_if

`default_nettype wire

//--- fdc_mem.sv
// Storage array of the FIFO with a registered read port.
// Assumes the controller holds rd_addr stable for at least two core cycles before use.
`default_nettype none

module fdc_mem
   import fdc_pkg::*;
#(
   parameter int unsigned DEPTH = FDC_DEPTH,
   parameter int unsigned DW    = FDC_DATA_W,
   parameter int unsigned AW    = FDC_ADDR_W
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Controller side
   fdc_mem_if.mem    bus
);

   logic [DW-1:0] store [DEPTH];
   logic [DW-1:0] rd_data_q;

   // No reset on the array so that it maps onto block memory
   always_ff @(posedge core_clk) begin
      if (bus.wr_en) begin
         store[bus.wr_addr] <= bus.wr_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= store[bus.rd_addr];
      end
   end

   assign bus.rd_data = rd_data_q;

endmodule : fdc_mem

`default_nettype wire

//--- fdc_ctrl.sv
// Control logic of a deep FIFO with separate write and read port clocks.
// Assumes both port clocks and all pins are slow against core_clk (port clock period of 8 core cycles or more).
//
// Operation
// - Master reset clears both pointers; almost-empty low, almost-full and half-full high.
// - Mode pin at master reset picks standard or fall-through, with matching flag levels.
// - Load low at master reset: offsets 127, parallel loading only afterwards.
// - Load high at master reset: offsets 1023, serial loading only afterwards.
// - Offset registers can always be read back in parallel.
// - Master reset is clock independent and zeroes the output data register.
// - Partial reset clears pointers and sets partial flags as master reset does.
// - Partial reset keeps timing mode and sets full/empty pins by that mode.
// - Partial reset keeps offsets and loading method, zeroes output data.
// - Replay low at a read clock edge starts setup; enables held high before.
// - Standard replay: empty low during setup, high after; every read needs enable.
// - Fall-through replay: ready high in setup, then first word shown without enable.
// - Fall-through: first word reaches outputs on third read edge without enable.
// - Standard mode: a word is shown only with read enable low at edge.
// - After master reset, mode pin is the serial offset input when serial chosen.
// - Writes on write edges; write side flags update there; half-full only lowered.
// - Reads on read edges; read side flags update there; half-full only raised.
// - Write enable low and not full stores one word per write edge.
// - Standard: full low when no space; high two write edges after a read.
// - Fall-through: input-ready high when no space; low two write edges after read.
// - Read enable low and not empty loads next word; otherwise output holds.
// - Master reset points both offset pointers at the empty offset; partial keeps them.
`default_nettype none

module fdc_ctrl
   import fdc_pkg::*;
#(
   parameter int unsigned DEPTH  = FDC_DEPTH,
   parameter int unsigned DATA_W = FDC_DATA_W,
   parameter int unsigned ADDR_W = FDC_ADDR_W
) (
   // Core clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   // Write port pins
   input  wire logic              wr_clk,
   input  wire logic              wr_en_n,
   input  wire logic [DATA_W-1:0] data_in,
   // Read port pins
   input  wire logic              rd_clk,
   input  wire logic              rd_en_n,
   input  wire logic              replay_n,
   // Reset and programming pins
   input  wire logic              full_reset_n,
   input  wire logic              pointer_only_reset_n,
   input  wire logic              mode_select_serial_in,
   input  wire logic              offset_load_n,
   input  wire logic              serial_en_n,
   // Data and flags
   output logic      [DATA_W-1:0] data_out,
   output logic                   empty_n,
   output logic                   full_n,
   output logic                   almost_empty_n,
   output logic                   almost_full_n,
   output logic                   half_full_n
);

   localparam int unsigned PW = ADDR_W + 1;
   localparam int unsigned SW = $clog2(2 * FDC_OFS_W);
   localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
   localparam logic [PW-1:0] HALF_P  = PW'(DEPTH / 2);
   localparam logic [SW-1:0] SER_LAST = SW'(2 * FDC_OFS_W - 1);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [FDC_PIN_W-1:0] pin_raw;
   logic [FDC_PIN_W-1:0] s1_q;
   logic [FDC_PIN_W-1:0] s2_q;
   logic [FDC_PIN_W-1:0] s3_q;
   logic [FDC_PIN_W-1:0] pin_q;
   logic [1:0]           clk_prev_q;

   assign pin_raw = {data_in, serial_en_n, offset_load_n, mode_select_serial_in, pointer_only_reset_n,
                     full_reset_n, replay_n, rd_en_n, rd_clk, wr_en_n, wr_clk};

   // A change is taken only once stages two and three agree
   for (genvar i = 0; i < FDC_PIN_W; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_q[i]  <= 1'b0;
            s2_q[i]  <= 1'b0;
            s3_q[i]  <= 1'b0;
            pin_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= pin_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               pin_q[i] <= s3_q[i];
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_prev_q <= 2'h0;
      end else begin
         clk_prev_q <= {pin_q[FDC_PIN_RCLK], pin_q[FDC_PIN_WCLK]};
      end
   end

   logic wr_edge;
   logic rd_edge;
   logic mrs_act;
   logic prs_act;
   logic ptr_clear;
   logic ld_low;
   logic mode_eff;

   assign wr_edge   = pin_q[FDC_PIN_WCLK] & ~clk_prev_q[0];
   assign rd_edge   = pin_q[FDC_PIN_RCLK] & ~clk_prev_q[1];
   assign mrs_act   = ~pin_q[FDC_PIN_MRS];
   assign prs_act   = ~pin_q[FDC_PIN_PRS];
   assign ptr_clear = mrs_act | prs_act;
   assign ld_low    = ~pin_q[FDC_PIN_LD];

   // ----------------------------------------------------------------
   // Settings caught at master reset
   // ----------------------------------------------------------------
   logic mode_q;
   logic serial_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q   <= 1'b0;
         serial_q <= 1'b0;
      end else if (mrs_act) begin
         mode_q   <= pin_q[FDC_PIN_MODE];
         serial_q <= pin_q[FDC_PIN_LD];
      end
   end

   assign mode_eff = mrs_act ? pin_q[FDC_PIN_MODE] : mode_q;

   // ----------------------------------------------------------------
   // Offset registers: empty offset low half, full offset high half
   // ----------------------------------------------------------------
   logic [2*FDC_OFS_W-1:0] ofs_q;
   logic                   ofs_wsel_q;
   logic                   ofs_rsel_q;
   logic [SW-1:0]          ser_idx_q;
   logic [FDC_OFS_W-1:0]   ofs_def;

   assign ofs_def = pin_q[FDC_PIN_LD] ? FDC_OFS_SERIAL_DEF : FDC_OFS_PARALLEL_DEF;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ofs_q      <= '0;
         ofs_wsel_q <= 1'b0;
         ser_idx_q  <= '0;
      end else if (mrs_act) begin
         ofs_q      <= {ofs_def, ofs_def};
         ofs_wsel_q <= 1'b0;
         ser_idx_q  <= '0;
      end else if (wr_edge && ld_low && !prs_act) begin
         if (!serial_q && !pin_q[FDC_PIN_WEN]) begin
            if (ofs_wsel_q) begin
               ofs_q[2*FDC_OFS_W-1:FDC_OFS_W] <= pin_q[FDC_PIN_DATA +: FDC_OFS_W];
            end else begin
               ofs_q[FDC_OFS_W-1:0] <= pin_q[FDC_PIN_DATA +: FDC_OFS_W];
            end
            ofs_wsel_q <= ~ofs_wsel_q;
         end else if (serial_q && !pin_q[FDC_PIN_SEN]) begin
            ofs_q[ser_idx_q] <= pin_q[FDC_PIN_MODE];
            ser_idx_q        <= (ser_idx_q == SER_LAST) ? '0 : ser_idx_q + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Write side
   // ----------------------------------------------------------------
   logic [PW-1:0] wptr_q;
   logic [PW-1:0] rptr_q;
   logic [PW-1:0] rptr_w1_q;
   logic [PW-1:0] wptr_d;
   logic [PW-1:0] used_w;
   logic          full_flag;
   logic          wr_ok;
   logic          full_n_q;
   logic          almost_full_n_q;

   fdc_mem_if #(.DW(DATA_W), .AW(ADDR_W)) mem ();

   assign full_flag = mode_q ? full_n_q : ~full_n_q;
   assign wr_ok  = wr_edge & ~pin_q[FDC_PIN_WEN] & ~ld_low & ~full_flag & ~ptr_clear;
   assign wptr_d = wr_ok ? wptr_q + 1'b1 : wptr_q;
   assign used_w = wptr_d - rptr_w1_q;

   // write side flags only on write edges
   // read pointer seen after two write edges
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_q          <= '0;
         rptr_w1_q       <= '0;
         full_n_q        <= 1'b1;
         almost_full_n_q <= 1'b1;
      end else if (ptr_clear) begin
         wptr_q          <= '0;
         rptr_w1_q       <= '0;
         full_n_q        <= ~mode_eff;
         almost_full_n_q <= 1'b1;
      end else if (wr_edge) begin
         wptr_q          <= wptr_d;
         rptr_w1_q       <= rptr_q;
         full_n_q        <= mode_q ? (used_w == DEPTH_P) : (used_w != DEPTH_P);
         almost_full_n_q <= (DEPTH_P - used_w) > PW'(ofs_q[2*FDC_OFS_W-1:FDC_OFS_W]);
      end
   end

   // ----------------------------------------------------------------
   // Read side
   // ----------------------------------------------------------------
   fdc_rd_state_type rd_state_q;
   fdc_rd_state_type rd_state_d;
   logic [PW-1:0]     rptr_d;
   logic [PW-1:0]     wptr_r1_q;
   logic [PW-1:0]     wptr_r2_q;
   logic              out_valid_q;
   logic              out_valid_d;
   logic              load_mem;
   logic              load_ofs;
   logic              mem_has;
   logic              rd_req;
   logic              empty_n_q;
   logic              almost_empty_n_q;
   logic [DATA_W-1:0] data_out_q;

   assign mem_has = rptr_q != wptr_r2_q;
   assign rd_req  = ~pin_q[FDC_PIN_REN];

   always_comb begin
      rd_state_d  = rd_state_q;
      rptr_d      = rptr_q;
      out_valid_d = out_valid_q;
      load_mem    = 1'b0;
      load_ofs    = 1'b0;
      if (rd_edge) begin
         case (rd_state_q)
            FDC_RD_REPLAY: begin
               rd_state_d = FDC_RD_RUN;
               if (mode_q && wptr_r1_q != '0) begin
                  load_mem    = 1'b1;
                  rptr_d      = PW'(1);
                  out_valid_d = 1'b1;
               end
            end
            default: begin
               if (!pin_q[FDC_PIN_RT]) begin
                  rd_state_d  = FDC_RD_REPLAY;
                  rptr_d      = '0;
                  out_valid_d = 1'b0;
               end else if (ld_low && rd_req) begin
                  load_ofs = 1'b1;
               end else begin
                  load_mem    = mem_has & (mode_q ? (~out_valid_q | rd_req) : rd_req);
                  rptr_d      = load_mem ? rptr_q + 1'b1 : rptr_q;
                  out_valid_d = load_mem | (out_valid_q & ~rd_req);
               end
            end
         endcase
      end
   end

   // read side flags only on read edges
   // write pointer seen after two read edges
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_state_q       <= FDC_RD_RUN;
         rptr_q           <= '0;
         wptr_r1_q        <= '0;
         wptr_r2_q        <= '0;
         out_valid_q      <= 1'b0;
         empty_n_q        <= 1'b0;
         almost_empty_n_q <= 1'b0;
      end else if (ptr_clear) begin
         rd_state_q       <= FDC_RD_RUN;
         rptr_q           <= '0;
         wptr_r1_q        <= '0;
         wptr_r2_q        <= '0;
         out_valid_q      <= 1'b0;
         empty_n_q        <= mode_eff;
         almost_empty_n_q <= 1'b0;
      end else if (rd_edge) begin
         rd_state_q       <= rd_state_d;
         rptr_q           <= rptr_d;
         wptr_r1_q        <= wptr_q;
         wptr_r2_q        <= wptr_r1_q;
         out_valid_q      <= out_valid_d;
         almost_empty_n_q <= (wptr_r1_q - rptr_d) > PW'(ofs_q[FDC_OFS_W-1:0]);
         if (rd_state_d == FDC_RD_REPLAY) begin
            empty_n_q <= mode_q;
         end else begin
            empty_n_q <= mode_q ? ~out_valid_d : (rptr_d != wptr_r1_q);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out_q <= '0;
      end else if (ptr_clear) begin
         data_out_q <= '0;
      end else if (load_ofs) begin
         data_out_q <= DATA_W'(ofs_rsel_q ? ofs_q[2*FDC_OFS_W-1:FDC_OFS_W] : ofs_q[FDC_OFS_W-1:0]);
      end else if (load_mem) begin
         data_out_q <= mem.rd_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ofs_rsel_q <= 1'b0;
      end else if (mrs_act) begin
         ofs_rsel_q <= 1'b0;
      end else if (load_ofs) begin
         ofs_rsel_q <= ~ofs_rsel_q;
      end
   end

   // Write side only lowers, read side only raises
   logic half_full_n_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_full_n_q <= 1'b1;
      end else if (ptr_clear) begin
         half_full_n_q <= 1'b1;
      end else if (wr_edge && used_w > HALF_P) begin
         half_full_n_q <= 1'b0;
      end else if (rd_edge && (wptr_r1_q - rptr_d) <= HALF_P) begin
         half_full_n_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   assign mem.wr_en   = wr_ok;
   assign mem.wr_addr = wptr_q[ADDR_W-1:0];
   assign mem.wr_data = pin_q[FDC_PIN_DATA +: DATA_W];
   // Read address runs ahead of the edge; needs slow port clocks
   assign mem.rd_addr = rptr_q[ADDR_W-1:0];

   fdc_mem #(.DEPTH(DEPTH), .DW(DATA_W), .AW(ADDR_W)) u_mem (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .bus      (mem)
   );

   assign data_out       = data_out_q;
   assign empty_n        = empty_n_q;
   assign full_n         = full_n_q;
   assign almost_empty_n = almost_empty_n_q;
   assign almost_full_n  = almost_full_n_q;
   assign half_full_n    = half_full_n_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_mrs_clears_ptrs: assert property (mrs_act |=> (wptr_q == '0 && rptr_q == '0 && !almost_empty_n_q
      && almost_full_n_q && half_full_n_q)) else $error("master reset left pointers or flags");
   a_mrs_mode_pins: assert property (mrs_act |=> (empty_n_q == $past(pin_q[FDC_PIN_MODE])
      && full_n_q != $past(pin_q[FDC_PIN_MODE]))) else $error("mode pins wrong at master reset");
   a_mrs_par_ofs: assert property ((mrs_act && !pin_q[FDC_PIN_LD]) |=>
      ofs_q == {FDC_OFS_PARALLEL_DEF, FDC_OFS_PARALLEL_DEF}) else $error("parallel default offset wrong");
   a_reset_zero_data: assert property (ptr_clear |=> data_out_q == '0) else $error("output not zeroed");
   a_prs_keeps_ofs: assert property ((prs_act && !mrs_act) |=> $stable(ofs_q) && $stable(mode_q))
      else $error("partial reset changed settings");
   a_wr_never_full: assert property (wr_ok |-> !full_flag) else $error("write while full");
   a_wr_ptr_step: assert property (wr_ok |=> wptr_q == $past(wptr_q) + 1'b1)
      else $error("write pointer did not step");
   a_std_read_enable: assert property ((rd_edge && !mode_q && !rd_req && pin_q[FDC_PIN_RT]
      && rd_state_q == FDC_RD_RUN && !ptr_clear) |=> $stable(rptr_q)) else $error("read without enable");
   a_replay_std_empty: assert property ((rd_edge && !mode_q && !pin_q[FDC_PIN_RT]
      && rd_state_q == FDC_RD_RUN && !ptr_clear) |=> !empty_n_q && rptr_q == '0) else $error("replay setup");
   a_replay_ft_ready: assert property ((rd_edge && mode_q && !pin_q[FDC_PIN_RT]
      && rd_state_q == FDC_RD_RUN && !ptr_clear) |=> empty_n_q) else $error("replay ready not high");
   a_hf_rise_by_read: assert property ($rose(half_full_n_q) |-> $past(rd_edge || ptr_clear))
      else $error("half-full raised without read edge");
   a_hf_fall_by_write: assert property ($fell(half_full_n_q) |-> $past(wr_edge))
      else $error("half-full lowered without write edge");

   c_write: cover property (wr_ok);
   c_full: cover property (full_flag);
   c_read: cover property (rd_edge && load_mem);
   c_replay: cover property (rd_state_q == FDC_RD_REPLAY ##1 rd_state_q == FDC_RD_RUN);

endmodule : fdc_ctrl

`default_nettype wire

//--- fdc_port_model.sv
// Writer and reader logic that clocks both FIFO ports.
// Assumes the bench requests one port clock cycle at a time.
`default_nettype none

module fdc_port_model (
   // Core clock
   input  wire logic core_clk,
   // Cycle requests
   input  wire logic wr_go,
   input  wire logic rd_go,
   // Port clocks
   output logic      wr_clk,
   output logic      rd_clk
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wcnt_q = 4'h0;
   logic [3:0] rcnt_q = 4'h0;

   // ------------------------------
   // Port clocks, 8 core cycles each
   // ------------------------------
   // Clocks stand still between cycles
   always_ff @(posedge core_clk) begin
      if (wr_go) wcnt_q <= 4'h8;
      else if (wcnt_q != 4'h0) wcnt_q <= wcnt_q - 4'h1;
      if (rd_go) rcnt_q <= 4'h8;
      else if (rcnt_q != 4'h0) rcnt_q <= rcnt_q - 4'h1;
   end
   assign wr_clk = (wcnt_q > 4'h4);
   assign rd_clk = (rcnt_q > 4'h4);
endmodule : fdc_port_model

`default_nettype wire

//--- tb.sv
// Bench for the FIFO control: resets, offsets, writes, reads, full, replay.
// Assumes fdc_ctrl is the top and the port model makes both port clocks.
`default_nettype none

module tb
   import fdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk = 1'b0, rst_n = 1'b0, wr_go = 1'b0, rd_go = 1'b0, wr_clk, rd_clk;
   logic        wr_en_n, rd_en_n, replay_n, full_reset_n, pointer_only_reset_n;
   logic        mode_select_serial_in, offset_load_n, serial_en_n;
   logic [17:0] data_in, data_out;
   logic        empty_n, full_n, almost_empty_n, almost_full_n, half_full_n;
   logic [4:0]  flg;
   int          err_total = 0, n_compared = 0, cycles = 0;

   assign flg = {empty_n, full_n, almost_empty_n, almost_full_n, half_full_n};
   fdc_port_model pm (.core_clk(core_clk), .wr_go(wr_go), .rd_go(rd_go), .wr_clk(wr_clk), .rd_clk(rd_clk));
   // Small depth keeps the full test short
   fdc_ctrl #(.DEPTH(16), .ADDR_W(4)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .wr_clk(wr_clk), .wr_en_n(wr_en_n), .data_in(data_in),
      .rd_clk(rd_clk), .rd_en_n(rd_en_n), .replay_n(replay_n), .full_reset_n(full_reset_n),
      .pointer_only_reset_n(pointer_only_reset_n), .mode_select_serial_in(mode_select_serial_in),
      .offset_load_n(offset_load_n), .serial_en_n(serial_en_n), .data_out(data_out), .empty_n(empty_n),
      .full_n(full_n), .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
      .half_full_n(half_full_n));

   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk(input logic [17:0] seen, input logic [17:0] want);
      n_compared++;
      if (seen !== want) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic wait_c(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_c
   // One port clock cycle; pins were set an edge earlier
   task automatic pcyc(input logic rd);
      @(posedge core_clk);
      if (rd) rd_go <= 1'b1;
      else wr_go <= 1'b1;
      @(posedge core_clk);
      rd_go <= 1'b0;
      wr_go <= 1'b0;
      wait_c(8);
   endtask : pcyc
   task automatic mreset(input logic ft, input logic ld);
      full_reset_n          <= 1'b0;
      mode_select_serial_in <= ft;
      offset_load_n         <= ld;
      wait_c(10);
      chk({13'h0, flg}, {13'h0, ft, ~ft, 3'b011});
      chk(data_out, 18'h0);
      full_reset_n <= 1'b1;
      wait_c(8);
      offset_load_n <= 1'b1;
      wait_c(8);
   endtask : mreset
   task automatic ofs_rd(input logic [17:0] want);
      offset_load_n <= 1'b0;
      rd_en_n       <= 1'b0;
      pcyc(1'b1);
      offset_load_n <= 1'b1;
      rd_en_n       <= 1'b1;
      chk(data_out, want);
   endtask : ofs_rd
   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   // ------------------------------
   // Clock, timeout, sequence
   // ------------------------------
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      {wr_en_n, rd_en_n, replay_n, pointer_only_reset_n, serial_en_n} = 5'h1f;
      {full_reset_n, mode_select_serial_in, offset_load_n} = 3'h0;
      data_in = 18'h0;
      wait_c(16);
      rst_n <= 1'b1;
      wait_c(4);
      mreset(1'b0, 1'b0);
      ofs_rd({5'h0, FDC_OFS_PARALLEL_DEF});
      ofs_rd({5'h0, FDC_OFS_PARALLEL_DEF});
      wr_en_n <= 1'b0;
      for (int i = 1; i <= 17; i++) begin
         data_in <= 18'(i);
         pcyc(1'b0);
      end
      wr_en_n <= 1'b1;
      chk({15'h0, full_n, half_full_n, almost_full_n}, 18'h0);
      pcyc(1'b1);
      pcyc(1'b1);
      chk({16'h0, empty_n, almost_empty_n}, 18'h2);
      chk(data_out, {5'h0, FDC_OFS_PARALLEL_DEF});
      rd_en_n <= 1'b0;
      pcyc(1'b1);
      rd_en_n <= 1'b1;
      chk(data_out, 18'h1);
      pcyc(1'b0);
      chk({17'h0, full_n}, 18'h0);
      pcyc(1'b0);
      chk({17'h0, full_n}, 18'h1);
      pcyc(1'b1);
      chk(data_out, 18'h1);
      rd_en_n <= 1'b0;
      for (int i = 2; i <= 17; i++) begin
         pcyc(1'b1);
         chk(data_out, 18'((i > 16) ? 16 : i));
      end
      rd_en_n <= 1'b1;
      chk({16'h0, empty_n, half_full_n}, 18'h1);
      // Standard replay: setup, then first word needs enable
      replay_n <= 1'b0;
      pcyc(1'b1);
      replay_n <= 1'b1;
      chk({17'h0, empty_n}, 18'h0);
      pcyc(1'b1);
      chk({17'h0, empty_n}, 18'h1);
      chk(data_out, 18'h10);
      rd_en_n <= 1'b0;
      pcyc(1'b1);
      rd_en_n <= 1'b1;
      chk(data_out, 18'h1);
      pointer_only_reset_n <= 1'b0;
      wait_c(10);
      chk({13'h0, flg}, {13'h0, 5'b01011});
      chk(data_out, 18'h0);
      pointer_only_reset_n <= 1'b1;
      wait_c(8);
      ofs_rd({5'h0, FDC_OFS_PARALLEL_DEF});
      mreset(1'b1, 1'b1);
      ofs_rd({5'h0, FDC_OFS_SERIAL_DEF});
      wr_en_n <= 1'b0;
      data_in <= 18'h0beef;
      pcyc(1'b0);
      data_in <= 18'h0cafe;
      pcyc(1'b0);
      wr_en_n <= 1'b1;
      pcyc(1'b1);
      pcyc(1'b1);
      chk(data_out, {5'h0, FDC_OFS_SERIAL_DEF});
      pcyc(1'b1);
      chk(data_out, 18'h0beef);
      chk({17'h0, empty_n}, 18'h0);
      rd_en_n <= 1'b0;
      pcyc(1'b1);
      rd_en_n <= 1'b1;
      chk(data_out, 18'h0cafe);
      replay_n <= 1'b0;
      pcyc(1'b1);
      replay_n <= 1'b1;
      chk({17'h0, empty_n}, 18'h1);
      pcyc(1'b1);
      chk(data_out, 18'h0beef);
      chk({17'h0, empty_n}, 18'h0);
      tally_and_finish();
   end
endmodule : tb

`default_nettype wire
